// ===== hdl/fsb_pkg.sv
// Purpose: constants and types shared by both ends of one 18-bit FIFO bank
// Assumes: write and read ports share one 100 MHz clock
// Notes: depth fixed at 256 words; offsets are 12 bits wide
//
// Overview of operation
// - Select pins sampled during configuration reset
// - Standard: first word waits for a read
// - Fall-through: first word shown after three edges
// - Write enable low stores word each edge
// - Standard empty flag low at zero words
// - Standard almost-empty high above n words
// - Standard half-full low above half depth
// - Standard almost-full low at depth minus m
// - Default offsets 31, 63 or 127
// - Standard full flag low at depth, blocks writes
// - Fall-through output-ready low when word shown
// - Fall-through almost-empty high above n+1
// - Fall-through half-full one word later
// - Fall-through almost-full low at depth+1-m
// - Fall-through input-ready high at depth+1
// - Read ignored while FIFO empty
// - Load writes alternate empty then full offset
// - Offset load order resumes across sessions
// - Load with read shows offsets alternately
// - Offset readback only in standard mode
// - Select code picks mode and flag style
// - Synchronous almost flags update on clock edges
package fsb_pkg;
	localparam int DATA_W = 18;
	localparam int OFF_W = 12;
	localparam int DEPTH = 256;
	localparam int ADDR_W = $clog2(DEPTH);
	localparam int CNT_W = 13;
	localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
	localparam logic [CNT_W-1:0] HALF_C = CNT_W'(DEPTH / 2);
	localparam logic [CNT_W-1:0] ONE_C = 13'h0001;
	localparam logic [OFF_W-1:0] OFF_DEFAULT = (DEPTH == 256) ? 12'h01f :
		(DEPTH == 512) ? 12'h03f : 12'h07f;
	// fall-through wait counter value on which the third edge loads
	localparam logic [1:0] FT_LAST = 2'h2;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CFG_HOLD_NS = 20;
	localparam int CFG_HOLD_CYC = (CFG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] CFG_HOLD_C = 2'(CFG_HOLD_CYC);
	// host spacing between strobes; covers double-buffered flag lag
	localparam logic [1:0] HOST_GAP = 2'h3;
	typedef enum logic [2:0] {
		CFG_STD = 3'b000,
		CFG_FALL = 3'b001,
		CFG_STD_DBL = 3'b010,
		CFG_STD_ALT = 3'b011,
		CFG_STD_SYNC = 3'b100
	} fsb_cfg_t;
endpackage

// ===== hdl/fsb_if.sv
// Purpose: pin bundle between the FIFO bank and its controller
// Assumes: all pins change on the shared clock
// Notes: active-low pins end in _n
`timescale 1ns/1ps
interface fsb_if
	import fsb_pkg::*;
();
	logic config_reset_n;
	logic first_load_select;
	logic read_expansion_in;
	logic write_expansion_in;
	logic write_en_n;
	logic offset_load_n;
	logic [DATA_W-1:0] din;
	logic read_en_n;
	logic [DATA_W-1:0] dout;
	logic empty_flag_n;
	logic output_ready_n;
	logic full_flag_n;
	logic input_ready_n;
	logic half_full_n;
	logic almost_empty_n;
	logic almost_full_n;

	modport dev (
		input config_reset_n, first_load_select, read_expansion_in, write_expansion_in,
		input write_en_n, offset_load_n, din, read_en_n,
		output dout, empty_flag_n, output_ready_n, full_flag_n, input_ready_n,
		output half_full_n, almost_empty_n, almost_full_n
	);
	modport host (
		output config_reset_n, first_load_select, read_expansion_in, write_expansion_in,
		output write_en_n, offset_load_n, din, read_en_n,
		input dout, empty_flag_n, output_ready_n, full_flag_n, input_ready_n,
		input half_full_n, almost_empty_n, almost_full_n
	);
endinterface

// ===== hdl/fsb_fifo_dev.sv
// Purpose: one 18-bit FIFO bank with mode select, flags and offsets
// Assumes: pins come from logic on the same clock, so no synchronisers
// Notes: flags are registered from the count after each edge
`timescale 1ns/1ps
module fsb_fifo_dev
	import fsb_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pin side
	fsb_if.dev bus,
	// user side
	output logic [CNT_W-1:0] fill_level
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		fsb_cfg_t cfg;
		logic [ADDR_W-1:0] wptr;
		logic [ADDR_W-1:0] rptr;
		logic [CNT_W-1:0] cnt;
		logic ov;
		logic [1:0] ft_wait;
		logic load_sel;
		logic rb_sel;
		logic [OFF_W-1:0] off_e;
		logic [OFF_W-1:0] off_f;
		logic [DATA_W-1:0] dout;
		logic empty_pre;
		logic full_pre;
		logic empty_n;
		logic full_n;
		logic or_n;
		logic in_rdy_n;
		logic half_n;
		logic aempty_n;
		logic afull_n;
		logic [CNT_W-1:0] level;
	} fsb_dev_st_t;

	localparam fsb_dev_st_t RST_ST = '{
		cfg: CFG_STD,
		off_e: OFF_DEFAULT,
		off_f: OFF_DEFAULT,
		full_pre: 1'b1,
		full_n: 1'b1,
		or_n: 1'b1,
		in_rdy_n: 1'b1,
		half_n: 1'b1,
		afull_n: 1'b1,
		default: '0
	};

	fsb_dev_st_t s_q;
	fsb_dev_st_t s_d;
	logic [DATA_W-1:0] mem [DEPTH];
	logic wr_do;
	logic rd_mem;
	logic fall;
	logic load_on;
	logic [CNT_W-1:0] tot;
	logic [CNT_W-1:0] asrc;

	// ************************************************************
	// decoding
	// ************************************************************
	// unlisted select codes fall back to plain standard timing
	function automatic fsb_cfg_t cfg_decode(input logic [2:0] code);
		unique case (code)
			3'b000: cfg_decode = CFG_STD;
			3'b001: cfg_decode = CFG_FALL;
			3'b010: cfg_decode = CFG_STD_DBL;
			3'b011: cfg_decode = CFG_STD_ALT;
			3'b100: cfg_decode = CFG_STD_SYNC;
			default: cfg_decode = CFG_STD;
		endcase
	endfunction

	function automatic logic cfg_fall(input fsb_cfg_t c);
		cfg_fall = (c == CFG_FALL);
	endfunction

	// ************************************************************
	// next state
	// ************************************************************
	always_comb
	begin
		s_d = s_q;
		wr_do = 1'b0;
		rd_mem = 1'b0;
		fall = cfg_fall(s_q.cfg);
		load_on = !bus.offset_load_n;
		tot = s_q.level;
		asrc = s_q.level;
		if (!bus.config_reset_n)
		begin
			// configuration reset clears the bank and takes the select code
			s_d = RST_ST;
			s_d.cfg = cfg_decode({bus.first_load_select, bus.read_expansion_in,
				bus.write_expansion_in});
			if (cfg_fall(s_d.cfg))
			begin
				s_d.empty_n = 1'b1;
				s_d.full_n = 1'b1;
				s_d.in_rdy_n = 1'b0;
			end
		end
		else
		begin
			// offset loading steals the write strobe from the memory
			if (load_on && !bus.write_en_n)
			begin
				if (s_q.load_sel)
					s_d.off_f = bus.din[OFF_W-1:0];
				else
					s_d.off_e = bus.din[OFF_W-1:0];
				s_d.load_sel = !s_q.load_sel;
			end
			// a full bank refuses the write even if a read comes along
			wr_do = !load_on && !bus.write_en_n && (s_q.cnt != DEPTH_C);

			if (!fall)
			begin
				if (load_on && !bus.read_en_n)
				begin
					s_d.dout = DATA_W'(s_q.rb_sel ? s_q.off_f : s_q.off_e);
					s_d.rb_sel = !s_q.rb_sel;
				end
				else if (!bus.read_en_n && s_q.cnt != '0)
				begin
					rd_mem = 1'b1;
					s_d.dout = mem[s_q.rptr];
				end
			end
			else
			begin
				// readback is not offered here; load with read does nothing
				if (!load_on && !bus.read_en_n && s_q.ov)
					s_d.ov = 1'b0;
				if (s_q.ov || s_q.cnt == '0)
					s_d.ft_wait = '0;
				else if (s_q.ft_wait != FT_LAST)
					s_d.ft_wait = s_q.ft_wait + 2'h1;
				else
					s_d.ft_wait = '0;
				// refill at once after a pop, otherwise after the third edge
				if (s_q.cnt != '0 && !s_d.ov && (s_q.ov || s_q.ft_wait == FT_LAST))
				begin
					rd_mem = 1'b1;
					s_d.ov = 1'b1;
					s_d.dout = mem[s_q.rptr];
				end
			end

			if (wr_do)
				s_d.wptr = s_q.wptr + 1'b1;
			if (rd_mem)
				s_d.rptr = s_q.rptr + 1'b1;
			s_d.cnt = s_q.cnt + CNT_W'(wr_do) - CNT_W'(rd_mem);
			tot = s_d.cnt + CNT_W'(s_d.ov);
			s_d.level = tot;
			// synchronous almost flags lag one edge behind the count
			asrc = (s_q.cfg == CFG_STD_SYNC) ? s_q.level : tot;

			if (!fall)
			begin
				s_d.empty_pre = (tot != '0);
				s_d.full_pre = (tot != DEPTH_C);
				// double buffering trades one edge of delay for settled flags
				s_d.empty_n = (s_q.cfg == CFG_STD_DBL) ? s_q.empty_pre : s_d.empty_pre;
				s_d.full_n = (s_q.cfg == CFG_STD_DBL) ? s_q.full_pre : s_d.full_pre;
				s_d.or_n = 1'b1;
				s_d.in_rdy_n = 1'b1;
				s_d.half_n = (tot <= HALF_C);
				s_d.aempty_n = (asrc > CNT_W'(s_q.off_e));
				s_d.afull_n = (asrc < DEPTH_C - CNT_W'(s_q.off_f));
			end
			else
			begin
				s_d.empty_n = 1'b1;
				s_d.full_n = 1'b1;
				s_d.or_n = !s_d.ov;
				s_d.in_rdy_n = (tot == DEPTH_C + ONE_C);
				s_d.half_n = (tot <= HALF_C + ONE_C);
				s_d.aempty_n = (tot > CNT_W'(s_q.off_e) + ONE_C);
				s_d.afull_n = (tot < DEPTH_C + ONE_C - CNT_W'(s_q.off_f));
			end
		end
	end

	// ************************************************************
	// storage
	// ************************************************************
	always_ff @(posedge clk)
	begin
		if (wr_do)
			mem[s_q.wptr] <= bus.din;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s_q <= RST_ST;
		else
			s_q <= s_d;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign bus.dout = s_q.dout;
	assign bus.empty_flag_n = s_q.empty_n;
	assign bus.full_flag_n = s_q.full_n;
	assign bus.output_ready_n = s_q.or_n;
	assign bus.input_ready_n = s_q.in_rdy_n;
	assign bus.half_full_n = s_q.half_n;
	assign bus.almost_empty_n = s_q.aempty_n;
	assign bus.almost_full_n = s_q.afull_n;
	assign fill_level = s_q.level;

endmodule

// ===== hdl/fsb_host.sv
// Purpose: producer and consumer controller that drives the FIFO bank pins
// Assumes: bank runs on the same clock; flags are trusted after a gap
// Notes: one strobe per HOST_GAP+1 cycles per side keeps flag lag safe
`timescale 1ns/1ps
module fsb_host
	import fsb_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pin side
	fsb_if.host bus,
	// configuration request
	input wire logic cfg_start,
	input wire logic [2:0] cfg_code,
	// producer side
	input wire logic wr_valid,
	input wire logic [DATA_W-1:0] wr_data,
	output logic wr_ready,
	// consumer side
	input wire logic rd_req,
	output logic rd_ready,
	output logic rd_valid,
	output logic [DATA_W-1:0] rd_data,
	// offset access
	input wire logic off_wr_valid,
	input wire logic [OFF_W-1:0] off_wr_data,
	input wire logic off_rd_req,
	output logic off_ready
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [1:0] cfg_cnt;
		logic cfg_rst_n;
		logic [2:0] code;
		logic fall;
		logic wen_n;
		logic ren_n;
		logic load_n;
		logic [DATA_W-1:0] din;
		logic [1:0] wgap;
		logic [1:0] rgap;
		logic [1:0] pend;
		logic rd_valid;
		logic [DATA_W-1:0] rd_data;
		logic wr_ready;
		logic rd_ready;
		logic off_ready;
	} fsb_host_st_t;

	// a configuration cycle in standard mode runs straight out of reset
	localparam fsb_host_st_t RST_ST = '{
		cfg_cnt: CFG_HOLD_C,
		wen_n: 1'b1,
		ren_n: 1'b1,
		load_n: 1'b1,
		default: '0
	};

	fsb_host_st_t s_q;
	fsb_host_st_t s_d;
	logic busy;

	always_comb
	begin
		s_d = s_q;
		s_d.wen_n = 1'b1;
		s_d.ren_n = 1'b1;
		s_d.load_n = 1'b1;
		s_d.rd_valid = 1'b0;
		s_d.wgap = (s_q.wgap != '0) ? s_q.wgap - 2'h1 : 2'h0;
		s_d.rgap = (s_q.rgap != '0) ? s_q.rgap - 2'h1 : 2'h0;
		s_d.pend = {s_q.pend[0], 1'b0};
		// fall-through data is taken before the pop lands, standard after the load
		if (s_q.fall ? s_q.pend[0] : s_q.pend[1])
		begin
			s_d.rd_valid = 1'b1;
			s_d.rd_data = bus.dout;
		end
		if (cfg_start)
		begin
			s_d.cfg_rst_n = 1'b0;
			s_d.code = cfg_code;
			s_d.fall = (cfg_code == CFG_FALL);
			s_d.cfg_cnt = CFG_HOLD_C;
		end
		else if (s_q.cfg_cnt != '0)
		begin
			// straps stay put for the whole low phase of the reset pin
			s_d.cfg_cnt = s_q.cfg_cnt - 2'h1;
			s_d.cfg_rst_n = (s_q.cfg_cnt == 2'h1);
		end
		else if (off_wr_valid && s_q.off_ready)
		begin
			s_d.load_n = 1'b0;
			s_d.wen_n = 1'b0;
			s_d.din = DATA_W'(off_wr_data);
			s_d.wgap = HOST_GAP;
		end
		else if (off_rd_req && s_q.off_ready && !s_q.fall)
		begin
			s_d.load_n = 1'b0;
			s_d.ren_n = 1'b0;
			s_d.pend[0] = 1'b1;
			s_d.rgap = HOST_GAP;
		end
		else
		begin
			if (wr_valid && s_q.wr_ready)
			begin
				s_d.wen_n = 1'b0;
				s_d.din = wr_data;
				s_d.wgap = HOST_GAP;
			end
			if (rd_req && s_q.rd_ready)
			begin
				s_d.ren_n = 1'b0;
				s_d.pend[0] = 1'b1;
				s_d.rgap = HOST_GAP;
			end
		end
		busy = cfg_start || s_d.cfg_cnt != '0 || !s_d.cfg_rst_n;
		s_d.wr_ready = !busy && s_d.wgap == '0 &&
			(s_d.fall ? !bus.input_ready_n : bus.full_flag_n);
		s_d.rd_ready = !busy && s_d.rgap == '0 &&
			(s_d.fall ? !bus.output_ready_n : bus.empty_flag_n);
		s_d.off_ready = !busy && s_d.wgap == '0 && s_d.rgap == '0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s_q <= RST_ST;
		else
			s_q <= s_d;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign bus.config_reset_n = s_q.cfg_rst_n;
	assign bus.first_load_select = s_q.code[2];
	assign bus.read_expansion_in = s_q.code[1];
	assign bus.write_expansion_in = s_q.code[0];
	assign bus.write_en_n = s_q.wen_n;
	assign bus.read_en_n = s_q.ren_n;
	assign bus.offset_load_n = s_q.load_n;
	assign bus.din = s_q.din;
	assign wr_ready = s_q.wr_ready;
	assign rd_ready = s_q.rd_ready;
	assign rd_valid = s_q.rd_valid;
	assign rd_data = s_q.rd_data;
	assign off_ready = s_q.off_ready;

endmodule

// ===== dv/fsb_pins_sva.sv
// Purpose: pin checks between the FIFO bank and its controller
// Assumes: one clock; straps read while config_reset_n is low
// Notes: flag order checks assume empty offsets below half depth
`timescale 1ns/1ps
module fsb_pins_sva
	import fsb_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// controller pins
	input wire logic config_reset_n,
	input wire logic first_load_select,
	input wire logic read_expansion_in,
	input wire logic write_expansion_in,
	input wire logic write_en_n,
	input wire logic offset_load_n,
	input wire logic [DATA_W-1:0] din,
	input wire logic read_en_n,
	// bank pins
	input wire logic [DATA_W-1:0] dout,
	input wire logic empty_flag_n,
	input wire logic output_ready_n,
	input wire logic full_flag_n,
	input wire logic input_ready_n,
	input wire logic half_full_n,
	input wire logic almost_empty_n,
	input wire logic almost_full_n
);
	// ***
	// mode tracking
	// ***
	logic fall_q;
	logic wr;
	logic rd;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			fall_q <= 1'h0;
		else if (!config_reset_n)
			fall_q <= {first_load_select, read_expansion_in, write_expansion_in} == 3'h1;
	end
	assign wr = !write_en_n && offset_load_n;
	assign rd = !read_en_n && offset_load_n;
	// ***
	// assertions
	// ***
	// a config reset rebuilds the bank, so nothing is judged while it runs
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst || !config_reset_n);
	sequence s_fall;
		output_ready_n [*3] ##1 (!output_ready_n && dout == $past(din, 4));
	endsequence
	a_first_word_falls: assert property (fall_q && output_ready_n && wr
		&& $past(write_en_n) && $past(write_en_n, 2) && $past(write_en_n, 3) |=> s_fall)
		else $error("no fall through");
	a_std_word_held: assert property (!fall_q && !empty_flag_n && read_en_n
		|=> $stable(dout))
		else $error("data moved without read");
	a_empty_leaves: assert property (!fall_q && !empty_flag_n && wr
		|-> ##[1:2] empty_flag_n)
		else $error("empty held after write");
	a_full_released: assert property (!fall_q && !full_flag_n && rd
		|-> ##[1:2] full_flag_n)
		else $error("full held after read");
	a_ready_released: assert property (fall_q && input_ready_n && rd
		|-> ##[1:2] !input_ready_n)
		else $error("input ready held after read");
	a_full_flags_agree: assert property ((!full_flag_n || fall_q && input_ready_n)
		|-> !almost_full_n && !half_full_n)
		else $error("full without partial flags");
	a_half_over_empty: assert property (!half_full_n |-> almost_empty_n)
		else $error("half full and almost empty");
	a_readback_upper: assert property (!fall_q && !offset_load_n && !read_en_n
		&& write_en_n |=> dout[DATA_W-1:OFF_W] == '0)
		else $error("readback upper bits set");
endmodule

// ===== dv/testbench.sv
// Purpose: drives the controller user side and judges the bank pins
// Assumes: both ends on one 100 MHz clock
// Notes: flags are judged once both sides have gone quiet
`timescale 1ns/1ps
module testbench
	import fsb_pkg::*;
;
	// ***
	// bench signals
	// ***
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic cfg_start = 1'h0;
	logic [2:0] cfg_code = 3'h0;
	logic wr_valid = 1'h0;
	logic [DATA_W-1:0] wr_data = 18'h0;
	logic rd_req = 1'h0;
	logic off_wr_valid = 1'h0;
	logic [OFF_W-1:0] off_wr_data = 12'h0;
	logic off_rd_req = 1'h0;
	logic fw = 1'h0;
	logic wr_ready;
	logic rd_ready;
	logic rd_valid;
	logic off_ready;
	logic [DATA_W-1:0] rd_data;
	logic [CNT_W-1:0] fill_level;
	int num_errors = 0;
	int samples_checked = 0;
	fsb_if bus();
	fsb_fifo_dev i_fsb_fifo_dev (.clk(clk), .rst(rst), .bus(bus), .fill_level(fill_level));
	fsb_host i_fsb_host (.clk(clk), .rst(rst), .bus(bus), .cfg_start(cfg_start),
		.cfg_code(cfg_code), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
		.rd_req(rd_req), .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.off_wr_valid(off_wr_valid), .off_wr_data(off_wr_data), .off_rd_req(off_rd_req),
		.off_ready(off_ready));
	fsb_pins_sva i_fsb_pins_sva (.clk(clk), .rst(rst), .config_reset_n(bus.config_reset_n),
		.first_load_select(bus.first_load_select), .read_expansion_in(bus.read_expansion_in),
		.write_expansion_in(bus.write_expansion_in), .write_en_n(bus.write_en_n),
		.offset_load_n(bus.offset_load_n), .din(bus.din), .read_en_n(bus.read_en_n),
		.dout(bus.dout), .empty_flag_n(bus.empty_flag_n), .output_ready_n(bus.output_ready_n),
		.full_flag_n(bus.full_flag_n), .input_ready_n(bus.input_ready_n),
		.half_full_n(bus.half_full_n), .almost_empty_n(bus.almost_empty_n),
		.almost_full_n(bus.almost_full_n));
	always #5 clk = ~clk;
	// ***
	// shared tasks
	// ***
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	function automatic logic sel(input int k);
		return k == 0 ? wr_ready : k == 1 ? rd_ready : k == 2 ? off_ready : rd_valid;
	endfunction
	// a ready that never comes shows up as a failed comparison
	task automatic wait_for(input int k);
		int t;
		t = 0;
		@(negedge clk);
		while (sel(k) !== 1'h1 && t < 40)
		begin
			@(negedge clk);
			t++;
		end
		chk(18'(sel(k)), 18'h1);
	endtask
	// controller spacing plus the longest flag lag
	task automatic settle();
		repeat (int'(HOST_GAP) + 3) @(negedge clk);
	endtask
	task automatic put(input logic [DATA_W-1:0] d);
		wait_for(0);
		wr_valid = 1'h1;
		wr_data = d;
		@(negedge clk);
		wr_valid = 1'h0;
	endtask
	task automatic take(input logic [DATA_W-1:0] exp);
		wait_for(1);
		rd_req = 1'h1;
		@(negedge clk);
		rd_req = 1'h0;
		wait_for(3);
		chk(rd_data, exp);
	endtask
	task automatic chk_flags(input int c, input int n, input int m);
		int x;
		logic [4:0] e;
		logic [4:0] g;
		x = int'(fw);
		e = {(c == DEPTH + x) ~^ fw, c < DEPTH + x - m, c <= DEPTH / 2 + x, c > n + x,
			(c == 0) ~^ fw};
		g = {fw ? bus.input_ready_n : bus.full_flag_n, bus.almost_full_n, bus.half_full_n,
			bus.almost_empty_n, fw ? bus.output_ready_n : bus.empty_flag_n};
		chk(18'(g), 18'(e));
		chk(18'(fill_level), 18'(c));
	endtask
	task automatic setup_mode(input logic [2:0] code);
		cfg_code = code;
		cfg_start = 1'h1;
		@(negedge clk);
		cfg_start = 1'h0;
		fw = code == 3'h1;
		repeat (4) @(negedge clk);
		wait_for(0);
	endtask
	// ***
	// scenarios
	// ***
	task automatic run(input int total, input int n, input int m);
		int s;
		logic [DATA_W-1:0] last;
		s = total < DEPTH;
		last = bus.dout;
		for (int k = 0; k < total; k++)
		begin
			put(18'(k * 771 + 5));
			settle();
			if (k == 0)
				chk(bus.dout, fw ? 18'h5 : last);
			chk_flags(k + 1, n, m);
		end
		if (s)
		begin
			fork
				put(18'(total * 771 + 5));
				take(18'h5);
			join
			settle();
			chk_flags(total, n, m);
		end
		for (int j = s; j < total + s; j++)
		begin
			take(18'(j * 771 + 5));
			settle();
			chk_flags(total + s - 1 - j, n, m);
		end
		// an empty bank offers no read, so a request must change nothing;
		// in fall-through a readback request is refused as well
		last = bus.dout;
		chk(18'(rd_ready), 18'h0);
		rd_req = 1'h1;
		off_rd_req = fw;
		@(negedge clk);
		rd_req = 1'h0;
		off_rd_req = 1'h0;
		settle();
		chk(bus.dout, last);
		chk_flags(0, n, m);
		$display("test of %0d words done", total);
	endtask
	task automatic offsets();
		for (int k = 0; k < 4; k++)
		begin
			wait_for(2);
			off_wr_valid = k < 2;
			off_rd_req = k > 1;
			off_wr_data = k ? 12'h7 : 12'h5;
			@(negedge clk);
			off_wr_valid = 1'h0;
			off_rd_req = 1'h0;
			if (k > 1)
			begin
				wait_for(2);
				chk(bus.dout, k == 2 ? 18'h5 : 18'h7);
			end
		end
		$display("test of offset access done");
	endtask
	initial
	begin
		repeat (16) @(negedge clk);
		rst = 1'h0;
		wait_for(0);
		run(DEPTH, 31, 31);
		setup_mode(3'h1);
		run(DEPTH + 1, 31, 31);
		for (int i = 0; i < 3; i++)
		begin
			setup_mode(i == 0 ? 3'h2 : i == 1 ? 3'h4 : 3'h3);
			run(40, 31, 31);
		end
		setup_mode(3'h0);
		offsets();
		run(40, 5, 7);
		finish_test();
	end
	initial
	begin
		#400us;
		num_errors++;
		finish_test();
	end
endmodule
